// File: inc/afx_pkg.sv
// Purpose: shared types and constants of the execute unit
// Assumes: 8-bit data, 16-bit program counter and register pairs
// Notes:   counts are whole core clock cycles
package afx_pkg;

   // status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // cycle counts of each class
   localparam logic [2:0] CYC_BYTE   = 3'h1;
   localparam logic [2:0] CYC_WORD   = 3'h2;
   localparam logic [2:0] CYC_JUMP   = 3'h2;
   localparam logic [2:0] CYC_CALL   = 3'h3;
   localparam logic [2:0] CYC_RETURN = 3'h4;
   localparam logic [2:0] CYC_SKIP1  = 3'h2;
   localparam logic [2:0] CYC_SKIP2  = 3'h3;

   // fixed operands
   localparam logic [7:0]  ALL_ONES = 8'hFF;
   localparam logic [7:0]  NONE     = 8'h00;
   localparam logic [7:0]  MIN_NEG  = 8'h80;
   localparam logic [7:0]  MAX_POS  = 8'h7F;
   localparam logic [15:0] STEP_ONE = 16'h0001;
   localparam logic [15:0] SKIP_ONE = 16'h0002;
   localparam logic [15:0] SKIP_TWO = 16'h0003;

   typedef enum logic [4:0] {
      OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUBTRACT_WITH_CARRY,
      OP_AND, OP_OR, OP_EXCLUSIVE_OR, OP_INVERT_BITS,
      OP_ARITHMETIC_INVERSE, OP_SET_SELECTED_BITS,
      OP_CLEAR_SELECTED_BITS, OP_ADD_ONE, OP_SUBTRACT_ONE,
      OP_ZERO_SIGN_TEST, OP_ZERO_REGISTER, OP_FILL_ONES,
      OP_ADD_IMMEDIATE_WORD, OP_SUBTRACT_IMMEDIATE_WORD,
      OP_COMPARE_ONLY, OP_COMPARE_WITH_CARRY,
      OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL,
      OP_POINTER_CALL, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT,
      OP_EQUAL_COMPARE_SKIP, OP_SKIP_IF_REGISTER_BIT_LOW
   } afx_op_t;

   typedef struct packed {
      logic         valid;
      afx_op_t      op;
      logic         use_const;
      logic [7:0]   rd;
      logic [7:0]   rr;
      logic [7:0]   k;
      logic [2:0]   bit_sel;
      logic [15:0]  word;
      logic [5:0]   word_k;
      logic [15:0]  pc;
      logic [11:0]  offset;
      logic [15:0]  pointer;
      logic [15:0]  stack_ret;
      logic         next_two_word;
   } afx_req_t;

   typedef struct packed {
      logic         reg_we;
      logic [7:0]   data8;
      logic         word_we;
      logic [15:0]  data16;
      logic         pc_we;
      logic [15:0]  pc;
      logic         push_we;
      logic [15:0]  push_addr;
   } afx_res_t;

endpackage

// File: core/afx_execute.sv
// Purpose: arithmetic, logic and flow execution of an 8-bit core
// Assumes: decode supplies operand values, pc and stack return address
// Notes:   one request at a time; o_READY low while a multi-cycle op runs
// Function
// - add two bytes, optional carry in, set Z C N V H, one cycle
// - add constant to register pair, set Z C N V S, two cycles
// - subtract register or constant, set Z C N V H, one cycle
// - subtract with carry also takes carry off, one cycle
// - subtract constant from register pair, Z C N V S, two cycles
// - AND with register or constant, xor with register, Z N V
// - OR with register or constant, set Z N V, one cycle
// - invert bits as 0xFF minus value, set Z C N V
// - negate as 0x00 minus value, set Z C N V H
// - set bits by OR mask, clear bits by AND inverted mask
// - add or subtract one, set Z N V, keep carry
// - test ANDs register with itself, keeps value, sets Z N V
// - zero register sets Z N V; fill ones touches no flag
// - relative jump loads pc plus offset plus one, two cycles
// - pointer jump loads pc from pointer pair, two cycles
// - calls reach relative or pointer target in three cycles
// - equal compare skips 1 or 2 words, takes 1, 2 or 3 cycles
// - compares set Z N V C H and write no register
// - skip on clear bit advances pc 2 or 3, 1 to 3 cycles
`timescale 1ns/1ns
`default_nettype none
module afx_execute (
   // clock and reset
   input  wire logic              I_REF_CLK,
   input  wire logic              I_RESET,
   // decoded request
   input  wire afx_pkg::afx_req_t I_REQ,
   output logic                   O_READY,
   // results
   output logic                   O_DONE,
   output afx_pkg::afx_res_t      O_RES,
   output logic [7:0]             O_FLAGS
);

   logic [7:0]        sreg;
   logic [1:0]        cnt;
   logic              pend;
   afx_pkg::afx_res_t res;
   afx_pkg::afx_req_t req_q;

   afx_pkg::afx_res_t next_res;
   logic [7:0]        next_sreg;
   logic [2:0]        next_cycles;

   default clocking cb_core @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RESET);

   wire accept = I_REQ.valid && O_READY;
   wire [7:0] opd_b = I_REQ.use_const ? I_REQ.k : I_REQ.rr;
   wire       c_in  = sreg[afx_pkg::FLAG_C];
   wire       z_in  = sreg[afx_pkg::FLAG_Z];

   // carry forms chain the old carry and keep zero sticky
   wire carry_form = (I_REQ.op == afx_pkg::OP_ADD_CARRY)
                  || (I_REQ.op == afx_pkg::OP_SUBTRACT_WITH_CARRY)
                  || (I_REQ.op == afx_pkg::OP_COMPARE_WITH_CARRY);
   wire       cin_used = carry_form & c_in;

   // negate runs through the subtractor with a zero minuend
   wire is_neg  = (I_REQ.op == afx_pkg::OP_ARITHMETIC_INVERSE);
   wire [7:0] sub_a = is_neg ? afx_pkg::NONE : I_REQ.rd;
   wire [7:0] sub_b = is_neg ? I_REQ.rd : opd_b;
   wire [7:0] add_b = I_REQ.rr;

   wire [8:0] sum9  = {1'b0, I_REQ.rd} + {1'b0, add_b}
                    + {8'h00, cin_used};
   wire [8:0] diff9 = {1'b0, sub_a} - {1'b0, sub_b}
                    - {8'h00, cin_used};
   wire [7:0] sum   = sum9[7:0];
   wire [7:0] diff  = diff9[7:0];

   wire add_h = (I_REQ.rd[3] & add_b[3]) | (add_b[3] & ~sum[3])
              | (~sum[3] & I_REQ.rd[3]);
   wire add_v = (I_REQ.rd[7] & add_b[7] & ~sum[7])
              | (~I_REQ.rd[7] & ~add_b[7] & sum[7]);
   wire sub_h = (~sub_a[3] & sub_b[3]) | (sub_b[3] & diff[3])
              | (diff[3] & ~sub_a[3]);
   wire sub_v = (sub_a[7] & ~sub_b[7] & ~diff[7])
              | (~sub_a[7] & sub_b[7] & diff[7]);
   wire sub_z = carry_form ? (z_in & (diff == afx_pkg::NONE))
                           : (diff == afx_pkg::NONE);
   wire add_z = carry_form ? (z_in & (sum == afx_pkg::NONE))
                           : (sum == afx_pkg::NONE);

   // register pair arithmetic
   wire [15:0] wk     = {10'h000, I_REQ.word_k};
   wire [15:0] wsum   = I_REQ.word + wk;
   wire [15:0] wdiff  = I_REQ.word - wk;
   wire        is_wsub = (I_REQ.op == afx_pkg::OP_SUBTRACT_IMMEDIATE_WORD);
   wire [15:0] wres   = is_wsub ? wdiff : wsum;
   wire        w_hi7  = I_REQ.word[15];
   wire        w_v    = is_wsub ? (w_hi7 & ~wres[15]) : (~w_hi7 & wres[15]);
   wire        w_c    = is_wsub ? (wres[15] & ~w_hi7) : (~wres[15] & w_hi7);

   // logic results
   // test and clear act on the destination alone, whatever rr holds
   wire       is_tst = (I_REQ.op == afx_pkg::OP_ZERO_SIGN_TEST);
   wire       is_clr = (I_REQ.op == afx_pkg::OP_ZERO_REGISTER);
   wire [7:0] and_b  = is_tst ? I_REQ.rd : opd_b;
   wire [7:0] xor_b  = is_clr ? I_REQ.rd : I_REQ.rr;
   wire [7:0] and_r  = I_REQ.rd & and_b;
   wire [7:0] or_r   = I_REQ.rd | opd_b;
   wire [7:0] xor_r  = I_REQ.rd ^ xor_b;
   wire [7:0] inv_r  = afx_pkg::ALL_ONES - I_REQ.rd;
   wire [7:0] clr_r  = I_REQ.rd & (afx_pkg::ALL_ONES - I_REQ.k);
   wire [7:0] inc_r  = I_REQ.rd + 8'h01;
   wire [7:0] dcr_r  = I_REQ.rd - 8'h01;

   // flow targets
   wire [15:0] rel_target = I_REQ.pc + {{4{I_REQ.offset[11]}}, I_REQ.offset}
                          + afx_pkg::STEP_ONE;
   wire [15:0] ret_addr   = I_REQ.pc + afx_pkg::STEP_ONE;
   wire [15:0] skip_step  = I_REQ.next_two_word ? afx_pkg::SKIP_TWO
                                                : afx_pkg::SKIP_ONE;
   wire [15:0] skip_pc    = I_REQ.pc + skip_step;
   wire [2:0]  skip_cyc   = I_REQ.next_two_word ? afx_pkg::CYC_SKIP2
                                                : afx_pkg::CYC_SKIP1;
   wire bit_low = ~I_REQ.rr[I_REQ.bit_sel];
   wire equal   = (I_REQ.rd == I_REQ.rr);

   // write a byte result with Z N V S from it; v given
   function automatic logic [7:0] flags_znv(input logic [7:0] f,
                                            input logic [7:0] r,
                                            input logic       v);
      logic [7:0] o;
      o = f;
      o[afx_pkg::FLAG_Z] = (r == afx_pkg::NONE);
      o[afx_pkg::FLAG_N] = r[7];
      o[afx_pkg::FLAG_V] = v;
      o[afx_pkg::FLAG_S] = r[7] ^ v;
      return o;
   endfunction

   always_comb begin
      next_res       = '0;
      next_sreg      = sreg;
      next_cycles    = afx_pkg::CYC_BYTE;
      next_res.data8 = I_REQ.rd;
      unique case (I_REQ.op)
         afx_pkg::OP_ADD, afx_pkg::OP_ADD_CARRY: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = sum;
            next_sreg = flags_znv(sreg, sum, add_v);
            next_sreg[afx_pkg::FLAG_Z] = add_z;
            next_sreg[afx_pkg::FLAG_C] = sum9[8];
            next_sreg[afx_pkg::FLAG_H] = add_h;
         end
         afx_pkg::OP_SUBTRACT, afx_pkg::OP_SUBTRACT_WITH_CARRY,
         afx_pkg::OP_ARITHMETIC_INVERSE,
         afx_pkg::OP_COMPARE_ONLY, afx_pkg::OP_COMPARE_WITH_CARRY: begin
            next_res.reg_we = (I_REQ.op != afx_pkg::OP_COMPARE_ONLY)
                           && (I_REQ.op != afx_pkg::OP_COMPARE_WITH_CARRY);
            next_res.data8  = diff;
            next_sreg = flags_znv(sreg, diff, sub_v);
            next_sreg[afx_pkg::FLAG_Z] = sub_z;
            next_sreg[afx_pkg::FLAG_C] = diff9[8];
            next_sreg[afx_pkg::FLAG_H] = sub_h;
         end
         afx_pkg::OP_AND, afx_pkg::OP_ZERO_SIGN_TEST: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = and_r;
            next_sreg = flags_znv(sreg, and_r, 1'b0);
         end
         afx_pkg::OP_OR, afx_pkg::OP_SET_SELECTED_BITS: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = or_r;
            next_sreg = flags_znv(sreg, or_r, 1'b0);
         end
         afx_pkg::OP_EXCLUSIVE_OR, afx_pkg::OP_ZERO_REGISTER: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = xor_r;
            next_sreg = flags_znv(sreg, xor_r, 1'b0);
         end
         afx_pkg::OP_INVERT_BITS: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = inv_r;
            next_sreg = flags_znv(sreg, inv_r, 1'b0);
            next_sreg[afx_pkg::FLAG_C] = 1'b1;
         end
         afx_pkg::OP_CLEAR_SELECTED_BITS: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = clr_r;
            next_sreg = flags_znv(sreg, clr_r, 1'b0);
         end
         afx_pkg::OP_ADD_ONE: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = inc_r;
            next_sreg = flags_znv(sreg, inc_r, inc_r == afx_pkg::MIN_NEG);
         end
         afx_pkg::OP_SUBTRACT_ONE: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = dcr_r;
            next_sreg = flags_znv(sreg, dcr_r, dcr_r == afx_pkg::MAX_POS);
         end
         afx_pkg::OP_FILL_ONES: begin
            next_res.reg_we = 1'b1;
            next_res.data8  = afx_pkg::ALL_ONES;
         end
         afx_pkg::OP_ADD_IMMEDIATE_WORD,
         afx_pkg::OP_SUBTRACT_IMMEDIATE_WORD: begin
            next_cycles     = afx_pkg::CYC_WORD;
            next_res.word_we = 1'b1;
            next_res.data16  = wres;
            next_sreg[afx_pkg::FLAG_Z] = (wres == 16'h0000);
            next_sreg[afx_pkg::FLAG_N] = wres[15];
            next_sreg[afx_pkg::FLAG_V] = w_v;
            next_sreg[afx_pkg::FLAG_S] = wres[15] ^ w_v;
            next_sreg[afx_pkg::FLAG_C] = w_c;
         end
         afx_pkg::OP_RELATIVE_JUMP: begin
            next_cycles  = afx_pkg::CYC_JUMP;
            next_res.pc_we = 1'b1;
            next_res.pc    = rel_target;
         end
         afx_pkg::OP_POINTER_JUMP: begin
            next_cycles  = afx_pkg::CYC_JUMP;
            next_res.pc_we = 1'b1;
            next_res.pc    = I_REQ.pointer;
         end
         afx_pkg::OP_RELATIVE_CALL, afx_pkg::OP_POINTER_CALL: begin
            next_cycles        = afx_pkg::CYC_CALL;
            next_res.push_we   = 1'b1;
            next_res.push_addr = ret_addr;
            next_res.pc_we     = 1'b1;
            next_res.pc = (I_REQ.op == afx_pkg::OP_RELATIVE_CALL)
                        ? rel_target : I_REQ.pointer;
         end
         afx_pkg::OP_SUBROUTINE_EXIT, afx_pkg::OP_INTERRUPT_EXIT: begin
            next_cycles    = afx_pkg::CYC_RETURN;
            next_res.pc_we = 1'b1;
            next_res.pc    = I_REQ.stack_ret;
            if (I_REQ.op == afx_pkg::OP_INTERRUPT_EXIT) begin
               next_sreg[afx_pkg::FLAG_I] = 1'b1;
            end
         end
         afx_pkg::OP_EQUAL_COMPARE_SKIP: begin
            next_res.pc_we = equal;
            next_res.pc    = skip_pc;
            next_cycles    = equal ? skip_cyc : afx_pkg::CYC_BYTE;
         end
         afx_pkg::OP_SKIP_IF_REGISTER_BIT_LOW: begin
            next_res.pc_we = bit_low;
            next_res.pc    = skip_pc;
            next_cycles    = bit_low ? skip_cyc : afx_pkg::CYC_BYTE;
         end
      endcase
   end

   // a new op may start in the cycle the previous one reports done
   assign O_READY = (cnt == 2'h0);
   assign O_DONE  = pend && (cnt == 2'h0);
   assign O_RES   = res;
   assign O_FLAGS = sreg;

   // flags and results move at the accepting edge; done waits for the count
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         sreg <= afx_pkg::FLAGS_RESET;
         cnt  <= 2'h0;
         pend <= 1'b0;
         res  <= '0;
      end else if (accept) begin
         sreg <= next_sreg;
         cnt  <= 2'(next_cycles - 3'h1);
         pend <= 1'b1;
         res  <= next_res;
      end else begin
         cnt  <= (cnt == 2'h0) ? 2'h0 : cnt - 2'h1;
         pend <= pend && (cnt != 2'h0);
      end
   end

   // copy of the taken request, read only by the checks below
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         req_q <= '0;
      end else if (accept) begin
         req_q <= I_REQ;
      end
   end

   a_byte_add_sum: assert property (
      accept && I_REQ.op == afx_pkg::OP_ADD |=> O_DONE && O_RES.reg_we
      && O_RES.data8 == 8'(req_q.rd + req_q.rr))
      else $error("byte add result wrong");

   a_word_two_cycles: assert property (
      accept && I_REQ.op == afx_pkg::OP_ADD_IMMEDIATE_WORD
      |=> !O_READY ##1 O_DONE && O_RES.word_we
      && O_RES.data16 == req_q.word + {10'h000, req_q.word_k})
      else $error("word add not done in two cycles");

   a_step_keeps_carry: assert property (
      accept && (I_REQ.op == afx_pkg::OP_ADD_ONE
      || I_REQ.op == afx_pkg::OP_SUBTRACT_ONE)
      |=> O_FLAGS[afx_pkg::FLAG_C] == $past(O_FLAGS[afx_pkg::FLAG_C]))
      else $error("step by one changed carry");

   a_fill_no_flags: assert property (
      accept && I_REQ.op == afx_pkg::OP_FILL_ONES
      |=> $stable(O_FLAGS) && O_RES.data8 == afx_pkg::ALL_ONES)
      else $error("fill ones disturbed flags");

   a_jump_target: assert property (
      accept && I_REQ.op == afx_pkg::OP_RELATIVE_JUMP
      |=> !O_DONE ##1 O_DONE && O_RES.pc_we && O_RES.pc == req_q.pc
      + {{4{req_q.offset[11]}}, req_q.offset} + afx_pkg::STEP_ONE)
      else $error("relative jump target or timing wrong");

   a_call_pushes: assert property (
      accept && (I_REQ.op == afx_pkg::OP_RELATIVE_CALL
      || I_REQ.op == afx_pkg::OP_POINTER_CALL)
      |=> !O_READY [*2] ##1 O_DONE && O_RES.push_we
      && O_RES.push_addr == req_q.pc + afx_pkg::STEP_ONE)
      else $error("call push or timing wrong");

   a_exit_four: assert property (
      accept && I_REQ.op == afx_pkg::OP_INTERRUPT_EXIT
      |=> O_FLAGS[afx_pkg::FLAG_I] ##3 O_DONE && O_RES.pc == req_q.stack_ret)
      else $error("interrupt exit wrong");

   a_skip_equal: assert property (
      accept && I_REQ.op == afx_pkg::OP_EQUAL_COMPARE_SKIP
      && I_REQ.rd == I_REQ.rr && !I_REQ.next_two_word
      |=> !O_DONE ##1 O_DONE && O_RES.pc == req_q.pc + afx_pkg::SKIP_ONE)
      else $error("equal skip wrong");

   a_compare_nowrite: assert property (
      accept && I_REQ.op == afx_pkg::OP_COMPARE_ONLY
      |=> O_DONE && !O_RES.reg_we && O_FLAGS[afx_pkg::FLAG_Z]
      == (req_q.rd == (req_q.use_const ? req_q.k : req_q.rr)))
      else $error("compare wrote register or bad zero");

endmodule
`default_nettype wire

// File: test/afx_stack_model.sv
// Purpose: return stack side of the fetch and decode stage
// Assumes: a call pushes one address, an exit pops one
// Notes:   an empty stack reads back a changing pattern, never a stale one
`timescale 1ns/1ns
`default_nettype none
module afx_stack_model (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   // execute unit side
   input  wire afx_pkg::afx_req_t i_req,
   input  wire logic              i_ready,
   input  wire logic              i_done,
   input  wire afx_pkg::afx_res_t i_res,
   output logic [15:0]            o_stack_ret
);
   logic [15:0] stack [0:3];
   logic [2:0]  sp;
   logic        exit_op;
   logic [15:0] noise;
   assign o_stack_ret = (sp != 3'h0) ? stack[sp[1:0] - 2'h1] : noise;
   always @(posedge i_clk) begin
      if (i_reset) begin
         sp      <= 3'h0;
         exit_op <= 1'b0;
         noise   <= 16'h5A5A;
      end else begin
         noise <= {noise[14:0], ~noise[15]};
         if (i_req.valid && i_ready) begin
            exit_op <= (i_req.op == afx_pkg::OP_SUBROUTINE_EXIT) ||
                       (i_req.op == afx_pkg::OP_INTERRUPT_EXIT);
         end
         if (i_done && i_res.push_we) begin
            stack[sp[1:0]] <= i_res.push_addr;
            sp             <= sp + 3'h1;
         end else if (i_done && exit_op && sp != 3'h0) begin
            sp <= sp - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: directed checks of the execute unit
// Assumes: requests driven on the falling edge, valid held back to back
// Notes:   a new request goes out in the done cycle, so ops other than exits run back to back
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic              I_REF_CLK = 1'b0;
   logic              I_RESET   = 1'b1;
   afx_pkg::afx_req_t r;
   afx_pkg::afx_res_t res;
   logic              o_ready;
   logic              o_done;
   logic [7:0]        flags;
   logic [15:0]       top;
   logic [7:0]        ef;
   logic [2:0]        sc;
   logic [15:0]       spc;
   int                n_fail     = 0;
   int                n_compared = 0;

   always #5 I_REF_CLK = ~I_REF_CLK;

   afx_execute DUT (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_REQ(r),
      .O_READY(o_ready), .O_DONE(o_done), .O_RES(res), .O_FLAGS(flags));
   afx_stack_model PARTNER (.i_clk(I_REF_CLK), .i_reset(I_RESET),
      .i_req(r), .i_ready(o_ready), .i_done(o_done), .i_res(res),
      .o_stack_ret(top));

   task automatic give_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // called at a falling edge; returns at the falling edge of done
   task automatic go(input afx_pkg::afx_op_t op, input logic [2:0] n);
      int c;
      // exits read the stack: let the last push or pop land first
      if (op == afx_pkg::OP_SUBROUTINE_EXIT
          || op == afx_pkg::OP_INTERRUPT_EXIT) begin
         r.valid = 1'b0;
         @(negedge I_REF_CLK);
      end
      r.op = op;
      r.valid = 1'b1;
      r.stack_ret = top;
      chk("ready", 16'h1, {15'h0, o_ready});
      @(negedge I_REF_CLK);
      // valid stays up when the next op may be taken in the done cycle
      if (o_done !== 1'b1) r.valid = 1'b0;
      c = 1;
      while (o_done !== 1'b1 && c < 8) begin
         @(negedge I_REF_CLK);
         c++;
      end
      if (o_done !== 1'b1) begin
         n_fail++;
         give_verdict();
      end
      chk("cycles", {13'h0, n}, c[15:0]);
      chk("flags", {8'h0, ef}, {8'h0, flags});
   endtask

   task automatic arith(input afx_pkg::afx_op_t op, input logic sub, cf,
                        we, uc, input logic [7:0] a, b, d);
      logic [8:0] w;
      logic [4:0] hw;
      logic       ci;
      logic       v;
      ci = cf & ef[afx_pkg::FLAG_C];
      w  = sub ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + {1'b0, b} + ci;
      hw = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci
               : {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
      v  = (sub ? a[7] != b[7] : a[7] == b[7]) && (w[7] != a[7]);
      ef[afx_pkg::FLAG_Z] = (w[7:0] == 8'h00) && (!cf || ef[afx_pkg::FLAG_Z]);
      ef[afx_pkg::FLAG_C] = w[8];
      ef[afx_pkg::FLAG_H] = hw[4];
      ef[afx_pkg::FLAG_V] = v;
      ef[afx_pkg::FLAG_N] = w[7];
      ef[afx_pkg::FLAG_S] = w[7] ^ v;
      r.rd = d;
      r.rr = b;
      r.k = b;
      r.use_const = uc;
      go(op, afx_pkg::CYC_BYTE);
      chk("reg_we", {15'h0, we}, {15'h0, res.reg_we});
      if (we) chk("data8", {8'h0, w[7:0]}, {8'h0, res.data8});
   endtask

   task automatic lop(input afx_pkg::afx_op_t op, input logic uc,
                      input logic [7:0] a, b, e, input logic v);
      ef[afx_pkg::FLAG_V] = v;
      ef[afx_pkg::FLAG_N] = e[7];
      ef[afx_pkg::FLAG_S] = e[7] ^ v;
      ef[afx_pkg::FLAG_Z] = (e == 8'h00);
      r.rd = a;
      r.rr = b;
      r.k = b;
      r.use_const = uc;
      go(op, afx_pkg::CYC_BYTE);
      chk("reg_we", 16'h1, {15'h0, res.reg_we});
      chk("data8", {8'h0, e}, {8'h0, res.data8});
   endtask

   task automatic word(input afx_pkg::afx_op_t op, input logic sub,
                       input logic [15:0] w, input logic [5:0] k);
      logic [15:0] s;
      s = sub ? w - {10'h0, k} : w + {10'h0, k};
      ef[afx_pkg::FLAG_C] = sub ? s[15] & ~w[15] : ~s[15] & w[15];
      ef[afx_pkg::FLAG_V] = sub ? w[15] & ~s[15] : ~w[15] & s[15];
      ef[afx_pkg::FLAG_N] = s[15];
      ef[afx_pkg::FLAG_S] = s[15] ^ ef[afx_pkg::FLAG_V];
      ef[afx_pkg::FLAG_Z] = (s == 16'h0000);
      r.word = w;
      r.word_k = k;
      go(op, afx_pkg::CYC_WORD);
      chk("word_we", 16'h1, {15'h0, res.word_we});
      chk("data16", s, res.data16);
   endtask

   task automatic flow(input afx_pkg::afx_op_t op, input logic [2:0] n,
                       input logic push, input logic [15:0] epc);
      go(op, n);
      chk("pc_we", 16'h1, {15'h0, res.pc_we});
      chk("pc", epc, res.pc);
      chk("push_we", {15'h0, push}, {15'h0, res.push_we});
      if (push) chk("push_addr", r.pc + 16'h1, res.push_addr);
   endtask

   initial begin
      r = '0;
      ef = afx_pkg::FLAGS_RESET;
      repeat (16) @(posedge I_REF_CLK);
      @(negedge I_REF_CLK);
      I_RESET = 1'b0;
      chk("done", 16'h0, {15'h0, o_done});
      chk("rst flags", {8'h0, ef}, {8'h0, flags});
      arith(afx_pkg::OP_ADD,0,0,1,0,8'h0F,8'h01,8'h0F);
      arith(afx_pkg::OP_ADD,0,0,1,0,8'hFF,8'h01,8'hFF);
      arith(afx_pkg::OP_ADD_CARRY,0,1,1,0,8'h00,8'h00,8'h00);
      arith(afx_pkg::OP_SUBTRACT,1,0,1,1,8'h80,8'h01,8'h80);
      arith(afx_pkg::OP_SUBTRACT,1,0,1,0,8'h00,8'h01,8'h00);
      arith(afx_pkg::OP_SUBTRACT_WITH_CARRY,
            1,1,1,1,8'h05,8'h02,8'h05);
      arith(afx_pkg::OP_SUBTRACT_WITH_CARRY,
            1,1,1,0,8'h01,8'h01,8'h01);
      arith(afx_pkg::OP_COMPARE_ONLY,1,0,0,0,8'h12,8'h34,8'h12);
      arith(afx_pkg::OP_COMPARE_WITH_CARRY,
            1,1,0,0,8'h34,8'h34,8'h34);
      arith(afx_pkg::OP_COMPARE_ONLY,1,0,0,1,8'h7F,8'h80,8'h7F);
      arith(afx_pkg::OP_ARITHMETIC_INVERSE,
            1,0,1,0,8'h00,8'h80,8'h80);
      lop(afx_pkg::OP_AND,0,8'hF0,8'h3C,8'hF0&8'h3C,0);
      lop(afx_pkg::OP_AND,1,8'h0F,8'h80,8'h0F&8'h80,0);
      lop(afx_pkg::OP_EXCLUSIVE_OR,0,8'hA5,8'h0F,8'hA5^8'h0F,0);
      lop(afx_pkg::OP_OR,0,8'h40,8'h81,8'h40|8'h81,0);
      lop(afx_pkg::OP_OR,1,8'h00,8'h00,8'h00,0);
      lop(afx_pkg::OP_SET_SELECTED_BITS,1,8'h01,8'h90,8'h91,0);
      lop(afx_pkg::OP_CLEAR_SELECTED_BITS,
          1,8'hF3,8'h81,8'hF3&(8'hFF-8'h81),0);
      lop(afx_pkg::OP_ZERO_SIGN_TEST,0,8'h80,8'h00,8'h80,0);
      lop(afx_pkg::OP_ZERO_REGISTER,0,8'h6B,8'h00,8'h00,0);
      // clear carry first so invert really has to set it
      arith(afx_pkg::OP_ADD,0,0,1,0,8'h01,8'h01,8'h01);
      ef[afx_pkg::FLAG_C] = 1'b1;
      lop(afx_pkg::OP_INVERT_BITS,0,8'h55,8'h00,8'hFF-8'h55,0);
      lop(afx_pkg::OP_ADD_ONE,0,8'h7F,8'h00,8'h80,1);
      lop(afx_pkg::OP_SUBTRACT_ONE,0,8'h80,8'h00,8'h7F,1);
      r.rd = 8'h00;
      go(afx_pkg::OP_FILL_ONES, afx_pkg::CYC_BYTE);
      chk("data8", 16'h00FF, {8'h0, res.data8});
      word(afx_pkg::OP_ADD_IMMEDIATE_WORD,0,16'hFFFF,6'h01);
      word(afx_pkg::OP_ADD_IMMEDIATE_WORD,0,16'h7FC1,6'h3F);
      word(afx_pkg::OP_SUBTRACT_IMMEDIATE_WORD,1,16'h0000,6'h01);
      word(afx_pkg::OP_SUBTRACT_IMMEDIATE_WORD,1,16'h8000,6'h01);
      r.pc = 16'h0100;
      r.offset = 12'hFFE;
      r.pointer = 16'h1234;
      flow(afx_pkg::OP_RELATIVE_JUMP,
           afx_pkg::CYC_JUMP,0,16'h00FF);
      flow(afx_pkg::OP_POINTER_JUMP,
           afx_pkg::CYC_JUMP,0,16'h1234);
      r.offset = 12'h010;
      flow(afx_pkg::OP_RELATIVE_CALL,
           afx_pkg::CYC_CALL,1,16'h0111);
      r.pc = 16'h0111;
      flow(afx_pkg::OP_POINTER_CALL,
           afx_pkg::CYC_CALL,1,16'h1234);
      ef[afx_pkg::FLAG_I] = 1'b1;
      flow(afx_pkg::OP_INTERRUPT_EXIT,
           afx_pkg::CYC_RETURN,0,16'h0112);
      flow(afx_pkg::OP_SUBROUTINE_EXIT,
           afx_pkg::CYC_RETURN,0,16'h0101);
      r.pc = 16'h0200;
      r.bit_sel = 3'h4;
      for (int i = 0; i < 3; i++) begin
         r.next_two_word = (i == 2);
         r.rd = 8'h3C;
         r.rr = (i == 0) ? 8'h3D : 8'h3C;
         sc = (i == 0) ? afx_pkg::CYC_BYTE
            : (i == 1) ? afx_pkg::CYC_SKIP1 : afx_pkg::CYC_SKIP2;
         spc = (i == 2) ? 16'h0203 : 16'h0202;
         go(afx_pkg::OP_EQUAL_COMPARE_SKIP, sc);
         chk("pc_we", {15'h0, i != 0}, {15'h0, res.pc_we});
         if (i != 0) chk("pc", spc, res.pc);
         r.rr = (i == 0) ? 8'h10 : 8'hEF;
         go(afx_pkg::OP_SKIP_IF_REGISTER_BIT_LOW, sc);
         chk("pc_we", {15'h0, i != 0}, {15'h0, res.pc_we});
         if (i != 0) chk("pc", spc, res.pc);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
